// ---- core/bpus_sequencer.sv ----
// Behaviour
// [RULE1] Start only when isolated 12 V enable is set and bus is above 8.5 V.
// [RULE2] After start, wait 500 ms for the isolated bus to settle.
// [RULE3] Then enable the 6 main converters together; switch core rail stays off.
// [RULE4] Hold the shared ramp-sequence control low during converter internal startup.
// [RULE5] Release ramp-sequence control 120 ms after the main enables rose.
// [RULE6] Enable switch core rail about 100 ms after main supplies are full.
// [RULE7] With all 9 supplies good, wait 500 ms then release board reset.
// [RULE8] Shut down when 12 V enable drops or the bus falls below 8.5 V.
// [RULE9] On shutdown, switch core rail off at once; main converters keep ramping down.
// [RULE10] When input power falls below threshold, drop every converter enable.
// [RULE11] Assert board reset as soon as the 12 V enable is removed.
// [RULE12] Both linear regulator enables are held permanently asserted.
// [RULE13] Management controller sets 12 V enable only after power negotiation.
// [RULE14] Board reset is active low; delays are counters on a free-running clock.
`include "bpus_map.svh"

module bpus_sequencer #(
	parameter int SETTLE_CYC  = `BPUS_SETTLE_CYC,        // Bus settle delay
	parameter int STARTUP_CYC = `BPUS_STARTUP_CYC,       // Converter internal startup
	parameter int SWITCH_CYC  = `BPUS_SWITCH_DELAY_CYC,  // Delay before switch core rail
	parameter int RESET_CYC   = `BPUS_RESET_DELAY_CYC,   // Delay before reset release
	parameter int MAIN_CONV   = `BPUS_MAIN_CONV          // Number of main converters
) (
	input  wire logic                 clk,                  // Free-running supervisory clock
	input  wire logic                 rst_n,                // Async reset, active low
	input  wire logic                 iso12_enable,         // 12 V converter enable pin
	input  wire logic                 bus_above_thresh,     // Comparator: bus at least 8.5 V
	input  wire logic [MAIN_CONV-1:0] main_pgood,           // Main converter power-good
	input  wire logic                 switch_core_pgood,    // Switch core rail power-good
	input  wire logic                 transceiver_aux_ok,   // Linear aux rail measured good
	input  wire logic                 linear_2v5_ok,        // Linear 2.5 V rail measured good
	output logic      [MAIN_CONV-1:0] main_conv_en,         // Main converter enables
	output logic                      ramp_seq,             // Shared ramp-sequence control
	output logic                      switch_core_rail_en,  // Switch core converter enable
	output logic                      transceiver_aux_en,   // Linear aux regulator enable
	output logic                      linear_2v5_en,        // Linear 2.5 V regulator enable
	output logic                      board_reset_n         // Board startup reset, active low
);

	localparam int CW = `BPUS_CNT_W;

	// Refuse delay counts below one or too wide for the counter, and zero main converters, at elaboration
	if (SETTLE_CYC < 1 || STARTUP_CYC < 1 || SWITCH_CYC < 1 || RESET_CYC < 1)
	begin
		$error("bpus_sequencer: delay counts must be at least one cycle");
	end
	if (SETTLE_CYC >= (1 << CW) || STARTUP_CYC >= (1 << CW) ||
	    SWITCH_CYC >= (1 << CW) || RESET_CYC >= (1 << CW))
	begin
		$error("bpus_sequencer: delay count exceeds counter width");
	end
	if (MAIN_CONV < 1)
	begin
		$error("bpus_sequencer: at least one main converter required");
	end

	// Synchronised copies of the pin inputs
	localparam int SW = MAIN_CONV + 5;
	logic [SW-1:0] sync_in;
	logic [SW-1:0] sync_out;

	assign sync_in = {iso12_enable, bus_above_thresh, switch_core_pgood,
	                  transceiver_aux_ok, linear_2v5_ok, main_pgood};

	bpus_sync #(
		.WIDTH (SW)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (sync_in),
		.dout  (sync_out)
	);

	wire                 en_s     = sync_out[SW-1];
	wire                 bus_ok_s = sync_out[SW-2];
	wire                 sw_pg_s  = sync_out[SW-3];
	wire                 aux_ok_s = sync_out[SW-4];
	wire                 l25_ok_s = sync_out[SW-5];
	wire [MAIN_CONV-1:0] main_pg_s = sync_out[MAIN_CONV-1:0];

	bpus_pkg::bpus_state_t state_ff;
	bpus_pkg::bpus_state_t nxt_state;
	logic [CW-1:0]         cnt_ff;
	logic [CW-1:0]         nxt_cnt;
	logic [MAIN_CONV-1:0]  nxt_main_en;
	logic                  nxt_ramp;
	logic                  nxt_sw_en;
	logic                  nxt_rst_n;

	// Start and stop conditions
	wire start_ok  = en_s & bus_ok_s;                          // [RULE1]
	wire main_full = &main_pg_s;
	wire all_good  = main_full & sw_pg_s & aux_ok_s & l25_ok_s; // [RULE7]
	wire cnt_done  = (cnt_ff == '0);

	// Load value for the next timed state
	function automatic logic [CW-1:0] load_cnt(input int cyc);
		load_cnt = CW'(cyc - 1);
	endfunction

	// Sequencing; timed states count down to zero then advance
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 1'b1;
		case (state_ff)
			bpus_pkg::BPUS_OFF:
			begin
				if (start_ok)                                          // [RULE1]
				begin
					nxt_state = bpus_pkg::BPUS_SETTLE;
					nxt_cnt   = load_cnt(SETTLE_CYC);                  // [RULE2]
				end
			end
			bpus_pkg::BPUS_SETTLE:
			begin
				if (cnt_done)
				begin
					nxt_state = bpus_pkg::BPUS_STARTUP;                // [RULE3]
					nxt_cnt   = load_cnt(STARTUP_CYC);                 // [RULE5]
				end
			end
			bpus_pkg::BPUS_STARTUP:
			begin
				if (cnt_done)
					nxt_state = bpus_pkg::BPUS_RAMP;                   // [RULE5]
			end
			bpus_pkg::BPUS_RAMP:
			begin
				// Main rails rising; wait until all report full output
				if (main_full)
				begin
					nxt_state = bpus_pkg::BPUS_SW_DELAY;
					nxt_cnt   = load_cnt(SWITCH_CYC);                  // [RULE6]
				end
			end
			bpus_pkg::BPUS_SW_DELAY:
			begin
				if (cnt_done)
					nxt_state = bpus_pkg::BPUS_STABLE;                 // [RULE6]
			end
			bpus_pkg::BPUS_STABLE:
			begin
				// Restart the reset-release wait whenever any rail drops out
				if (!all_good)
					nxt_cnt = load_cnt(RESET_CYC);
				else if (cnt_done)
					nxt_state = bpus_pkg::BPUS_RUN;                    // [RULE7]
			end
			bpus_pkg::BPUS_RUN:
			begin
				nxt_state = bpus_pkg::BPUS_RUN;
			end
			default:
			begin
				nxt_state = bpus_pkg::BPUS_OFF;
			end
		endcase
		if (state_ff == bpus_pkg::BPUS_SW_DELAY && cnt_done)
			nxt_cnt = load_cnt(RESET_CYC);                             // [RULE7]
		// Loss of enable or bus ends any sequence, back to the idle state
		if (!start_ok)                                                 // [RULE8]
		begin
			nxt_state = bpus_pkg::BPUS_OFF;
			nxt_cnt   = '0;
		end
	end

	// Output decode from the next state so outputs leave flip-flops directly
	wire powering = (nxt_state != bpus_pkg::BPUS_OFF) &&
	                (nxt_state != bpus_pkg::BPUS_SETTLE);
	wire sw_phase = (nxt_state == bpus_pkg::BPUS_STABLE) ||
	                (nxt_state == bpus_pkg::BPUS_RUN);

	// Main enables stay up while only the 12 V enable is gone and the bus
	// still holds, so the converters ramp down on their own; a bus drop
	// removes them at once.
	assign nxt_main_en = (powering || (bus_ok_s && main_conv_en[0])) ?  // [RULE9]
	                     {MAIN_CONV{1'b1}} : {MAIN_CONV{1'b0}};          // [RULE3] [RULE10]
	// Ramp control low during startup, high afterwards while powered
	assign nxt_ramp  = powering && (nxt_state != bpus_pkg::BPUS_STARTUP); // [RULE4] [RULE5]
	assign nxt_sw_en = sw_phase;                                          // [RULE6] [RULE9]
	// Reset released only in run; asserted the moment the enable goes
	assign nxt_rst_n = (nxt_state == bpus_pkg::BPUS_RUN);                 // [RULE11] [RULE14]

	// State and counter registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= bpus_pkg::BPUS_OFF;
			cnt_ff   <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;                                           // [RULE14]
		end
	end

	// Registered outputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			main_conv_en        <= '0;
			ramp_seq            <= 1'b0;
			switch_core_rail_en <= 1'b0;
			board_reset_n       <= 1'b0;
			transceiver_aux_en  <= 1'b1;
			linear_2v5_en       <= 1'b1;
		end
		else
		begin
			main_conv_en        <= nxt_main_en;
			ramp_seq            <= nxt_ramp;
			switch_core_rail_en <= nxt_sw_en;
			board_reset_n       <= nxt_rst_n;
			transceiver_aux_en  <= 1'b1;                                   // [RULE12]
			linear_2v5_en       <= 1'b1;                                   // [RULE12]
		end
	end

endmodule

// ---- core/bpus_sync.sv ----
module bpus_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,    // System clock
	input  wire logic             rst_n,  // Async reset, active low
	input  wire logic [WIDTH-1:0] din,    // Asynchronous inputs
	output logic      [WIDTH-1:0] dout    // Synchronised copies
);

	logic [WIDTH-1:0] meta_ff;

	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			dout    <= '0;
		end
		else
		begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end

endmodule

// ---- inc/bpus_map.svh ----
`ifndef BPUS_MAP_SVH
`define BPUS_MAP_SVH

// Clock rate in kHz so that ms figures give cycles directly
`define BPUS_CLK_KHZ          40000
// Delays as printed, in milliseconds
`define BPUS_SETTLE_MS        500
`define BPUS_STARTUP_MS       120
`define BPUS_SWITCH_DELAY_MS  100
`define BPUS_RESET_DELAY_MS   500
// Derived cycle counts
`define BPUS_SETTLE_CYC       (`BPUS_SETTLE_MS * `BPUS_CLK_KHZ)
`define BPUS_STARTUP_CYC      (`BPUS_STARTUP_MS * `BPUS_CLK_KHZ)
`define BPUS_SWITCH_DELAY_CYC (`BPUS_SWITCH_DELAY_MS * `BPUS_CLK_KHZ)
`define BPUS_RESET_DELAY_CYC  (`BPUS_RESET_DELAY_MS * `BPUS_CLK_KHZ)
// Number of main converters and supplies
`define BPUS_MAIN_CONV        6
`define BPUS_ALL_SUPPLIES     9
// Counter width, enough for 20,000,000 cycles
`define BPUS_CNT_W            25

`endif

// ---- inc/bpus_pkg.sv ----
package bpus_pkg;

	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		BPUS_OFF      = 7'h01,
		BPUS_SETTLE   = 7'h02,
		BPUS_STARTUP  = 7'h04,
		BPUS_RAMP     = 7'h08,
		BPUS_SW_DELAY = 7'h10,
		BPUS_STABLE   = 7'h20,
		BPUS_RUN      = 7'h40
	} bpus_state_t;

endpackage

// ---- verification/bpus_rail_model.sv ----
module bpus_rail_model #(
	parameter int DLY = 4  // Ramp time in cycles
) (
	input wire logic       clk,                  // Clock
	input wire logic [5:0] main_conv_en,         // Main enables
	input wire logic       ramp_seq,             // Ramp control
	input wire logic       switch_core_rail_en,  // Core enable
	output logic     [5:0] main_pgood,           // Main good
	output logic           switch_core_pgood,    // Core good
	output logic           transceiver_aux_ok,   // Aux ok
	output logic           linear_2v5_ok         // 2.5 V ok
);
	timeunit 1ns;
	timeprecision 1ps;
	int c_m = 0;
	int c_s = 0;
	// No output ramp while the ramp control is held low
	always_ff @(posedge clk)
	begin
		c_m <= (&main_conv_en && ramp_seq) ? c_m + 1 : 0;
		c_s <= (switch_core_rail_en && main_pgood[5]) ? c_s + 1 : 0;
	end
	// Linear rails trail the 3.3 V rail by a cycle
	assign main_pgood = {6{c_m >= DLY}};
	assign switch_core_pgood = c_s >= DLY;
	assign transceiver_aux_ok = c_m > DLY;
	assign linear_2v5_ok = c_m > DLY;
endmodule

// ---- verification/bpus_sequencer_properties.sv ----
module bpus_seq_chk #(
	parameter int SETTLE_CYC  = 8,   // Settle delay
	parameter int STARTUP_CYC = 6,   // Startup delay
	parameter int SWITCH_CYC  = 5,   // Core rail delay
	parameter int RESET_CYC   = 10,  // Reset release delay
	parameter int MAIN_CONV   = 6    // Main converters
) (
	input wire logic                 clk,                  // Clock
	input wire logic                 rst_n,                // Reset
	input wire logic                 iso12_enable,         // 12 V enable
	input wire logic                 bus_above_thresh,     // Bus ok
	input wire logic [MAIN_CONV-1:0] main_pgood,           // Main good
	input wire logic                 switch_core_pgood,    // Core good
	input wire logic                 transceiver_aux_ok,   // Aux ok
	input wire logic                 linear_2v5_ok,        // 2.5 V ok
	input wire logic [MAIN_CONV-1:0] main_conv_en,         // Main enables
	input wire logic                 ramp_seq,             // Ramp control
	input wire logic                 switch_core_rail_en,  // Core enable
	input wire logic                 transceiver_aux_en,   // Aux enable
	input wire logic                 linear_2v5_en,        // 2.5 V enable
	input wire logic                 board_reset_n         // Board reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// All nine supplies good at once
	wire all_ok   = &main_pgood && switch_core_pgood && transceiver_aux_ok && linear_2v5_ok;
	wire start_in = iso12_enable && bus_above_thresh;  // Start condition at the pins
	wire main_all = &main_pgood;                       // All main rails good
	property p_lin; transceiver_aux_en && linear_2v5_en; endproperty
	a_lin: assert property (p_lin) else $error("linear enable low");
	property p_same; main_conv_en == '0 || &main_conv_en; endproperty
	a_same: assert property (p_same) else $error("main enables split");
	property p_start;
		$rose(main_conv_en[0]) |-> $past(start_in, SETTLE_CYC + 3);
	endproperty
	a_start: assert property (p_start) else $error("main enable timing");
	property p_ramp; $rose(main_conv_en[0]) |-> !ramp_seq[*6] ##1 ramp_seq; endproperty
	a_ramp: assert property (p_ramp) else $error("ramp release timing");
	property p_sw;
		$rose(switch_core_rail_en) |-> $past(main_all, SWITCH_CYC);
	endproperty
	a_sw: assert property (p_sw) else $error("core rail too early");
	property p_order; switch_core_rail_en |-> &main_conv_en && ramp_seq; endproperty
	a_order: assert property (p_order) else $error("core rail out of order");
	property p_rel;
		$rose(board_reset_n) |-> switch_core_rail_en && $past(all_ok, RESET_CYC);
	endproperty
	a_rel: assert property (p_rel) else $error("reset released early");
	property p_down;
		$fell(iso12_enable) |->
			##3 !switch_core_rail_en && !board_reset_n && !ramp_seq;
	endproperty
	a_down: assert property (p_down) else $error("shutdown outputs");
	property p_keep;
		($fell(iso12_enable) && &main_conv_en) ##1 bus_above_thresh[*3] |-> &main_conv_en;
	endproperty
	a_keep: assert property (p_keep) else $error("mains dropped early");
	property p_cut;
		$fell(bus_above_thresh) |->
			##3 main_conv_en == '0 && !switch_core_rail_en && !board_reset_n;
	endproperty
	a_cut: assert property (p_cut) else $error("power loss cut");
	c_up: cover property ($rose(board_reset_n));
	c_off: cover property ($fell(iso12_enable) && &main_conv_en);
	c_cut: cover property ($fell(bus_above_thresh) && &main_conv_en);
endmodule
bind bpus_sequencer bpus_seq_chk #(
	.SETTLE_CYC  (SETTLE_CYC),
	.STARTUP_CYC (STARTUP_CYC),
	.SWITCH_CYC  (SWITCH_CYC),
	.RESET_CYC   (RESET_CYC),
	.MAIN_CONV   (MAIN_CONV)
) u_chk (
	.clk                 (clk),
	.rst_n               (rst_n),
	.iso12_enable        (iso12_enable),
	.bus_above_thresh    (bus_above_thresh),
	.main_pgood          (main_pgood),
	.switch_core_pgood   (switch_core_pgood),
	.transceiver_aux_ok  (transceiver_aux_ok),
	.linear_2v5_ok       (linear_2v5_ok),
	.main_conv_en        (main_conv_en),
	.ramp_seq            (ramp_seq),
	.switch_core_rail_en (switch_core_rail_en),
	.transceiver_aux_en  (transceiver_aux_en),
	.linear_2v5_en       (linear_2v5_en),
	.board_reset_n       (board_reset_n)
);

// ---- verification/bpus_sequencer_test.sv ----
module bpus_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct { logic en; logic bus; int n; logic [3:0] e; } bpus_row_t;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic iso12_enable, bus_above_thresh, switch_core_pgood, transceiver_aux_ok, linear_2v5_ok;
	logic ramp_seq, switch_core_rail_en, transceiver_aux_en, linear_2v5_en, board_reset_n;
	logic [5:0] main_pgood, main_conv_en;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	// Expected {mains, ramp, core, reset release} after n cycles
	bpus_row_t rows [11] = '{'{1'h1, 1'h0, 20, 4'h0}, '{1'h0, 1'h1, 20, 4'h0},
		'{1'h1, 1'h1, 8, 4'h0}, '{1'h1, 1'h1, 5, 4'h8}, '{1'h1, 1'h1, 10, 4'hc},
		'{1'h1, 1'h1, 12, 4'he}, '{1'h1, 1'h1, 25, 4'hf}, '{1'h0, 1'h1, 4, 4'h8},
		'{1'h0, 1'h0, 4, 4'h0}, '{1'h1, 1'h1, 70, 4'hf}, '{1'h1, 1'h0, 4, 4'h0}};
	wire [10:0] outs = {main_conv_en, ramp_seq, switch_core_rail_en, board_reset_n,
		transceiver_aux_en, linear_2v5_en};
	// Short delays keep the run brief
	bpus_sequencer #(
		.SETTLE_CYC  (8),
		.STARTUP_CYC (6),
		.SWITCH_CYC  (5),
		.RESET_CYC   (10),
		.MAIN_CONV   (6)
	) u_bpus_sequencer (
		.clk                 (clk),
		.rst_n               (rst_n),
		.iso12_enable        (iso12_enable),
		.bus_above_thresh    (bus_above_thresh),
		.main_pgood          (main_pgood),
		.switch_core_pgood   (switch_core_pgood),
		.transceiver_aux_ok  (transceiver_aux_ok),
		.linear_2v5_ok       (linear_2v5_ok),
		.main_conv_en        (main_conv_en),
		.ramp_seq            (ramp_seq),
		.switch_core_rail_en (switch_core_rail_en),
		.transceiver_aux_en  (transceiver_aux_en),
		.linear_2v5_en       (linear_2v5_en),
		.board_reset_n       (board_reset_n)
	);
	bpus_rail_model #(
		.DLY (4)
	) u_bpus_rail_model (
		.clk                 (clk),
		.main_conv_en        (main_conv_en),
		.ramp_seq            (ramp_seq),
		.switch_core_rail_en (switch_core_rail_en),
		.main_pgood          (main_pgood),
		.switch_core_pgood   (switch_core_pgood),
		.transceiver_aux_ok  (transceiver_aux_ok),
		.linear_2v5_ok       (linear_2v5_ok)
	);
	always #12.5 clk = ~clk;
	task automatic chk(input logic [10:0] exp, input logic [10:0] got);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("Compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			errors++;
			wrap_up();
		end
	end
	initial
	begin
		iso12_enable = 1'h0;
		bus_above_thresh = 1'h0;
		repeat (12) @(negedge clk);
		chk(11'h003, outs);
		rst_n = 1'h1;
		foreach (rows[i])
		begin
			@(negedge clk);
			iso12_enable = rows[i].en;
			bus_above_thresh = rows[i].bus;
			repeat (rows[i].n) @(negedge clk);
			chk({{6{rows[i].e[3]}}, rows[i].e[2:0], 2'h3}, outs);
		end
		// Reset in mid-sequence clears at once, restart waits again
		iso12_enable = 1'h1;
		bus_above_thresh = 1'h1;
		repeat (30) @(negedge clk);
		rst_n = 1'h0;
		#1 chk(11'h003, outs);
		@(negedge clk);
		rst_n = 1'h1;
		repeat (9) @(negedge clk);
		chk(11'h003, outs);
		// Mains come up once the fresh settle wait has run out, ramp still held
		repeat (3) @(negedge clk);
		chk(11'h7e3, outs);
		wrap_up();
	end
endmodule
